// [rtl/serial_port.sv]
// SPI mode of the synchronous serial port with AHB-Lite registers
`timescale 1ns/1ns
`include "serial_port_defines.svh"
module serial_port (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire serial_port_pkg::word_t haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire serial_port_pkg::word_t hwdata_i,
  input wire logic hready_i,
  output serial_port_pkg::word_t hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic ss_n_i,
  output logic irq_o
);
  import serial_port_pkg::*;

  core_state_t st_q;
  core_state_t st_d;
  pin_sync_if sp ();

  logic take;
  logic rd_buf;
  logic en;
  logic ckp;
  logic [3:0] mode;
  logic master;
  logic slave;
  logic use_ss;
  logic sel;
  logic sdi_s;
  logic sck_s;
  logic ss_s;
  logic [6:0] half;
  logic tick;
  logic odd;
  logic m_smp;
  logic m_out;
  logic chg;
  logic lead;
  logic trail;
  logic s_smp;
  logic s_out;

  ////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  assign sp.raw = {ss_n_i, sck_i, sdi_i};

  pin_sync u_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .sp(sp)
  );

  assign sdi_s = sp.sync[0];
  assign sck_s = sp.sync[1];
  assign ss_s = sp.sync[2];

  ////////////////////////////////////////////////////////////////////
  // Decode of the stored options

  assign en = st_q.ctl[`CTL_EN];
  assign ckp = st_q.ctl[`CTL_CKP];
  assign mode = st_q.ctl[3:0];
  assign master = (mode <= `MODE_DIV128);
  assign slave = (mode == `MODE_SLAVE_SS) ||
                 (mode == `MODE_SLAVE_NOSS);
  // Slave select only counts in the slave mode with select (MODE_SLAVE_SS)
  assign use_ss = (mode == `MODE_SLAVE_SS);
  assign sel = !use_ss || !ss_s;

  // Rate only applies to the master counter
  always_comb begin
    unique case (mode)
      `MODE_DIV16: half = `HALF_DIV16;
      `MODE_DIV64: half = `HALF_DIV64;
      `MODE_DIV128: half = `HALF_DIV128;
      default: half = `HALF_DIV4;
    endcase
  end

  // Master edge bookkeeping; edge 16 ends the word with no toggle
  assign tick = (st_q.ph == PH_RUN) && (st_q.div == 7'(half - 7'h01));
  assign odd = st_q.hcnt[0];
  always_comb begin
    if (st_q.input_sample_point) begin
      m_smp = st_q.cke ? odd : (!odd && st_q.hcnt != 5'h00);
    end else begin
      m_smp = (st_q.cke ? !odd : odd) &&
              (st_q.hcnt < `LAST_EDGE);
    end
  end
  assign m_out = (st_q.hcnt < `LAST_EDGE) &&
                 (st_q.cke ? odd : !odd);

  // Slave edges seen through the synchroniser
  assign chg = (sck_s != st_q.sck_h);
  assign lead = chg && (sck_s != ckp);
  assign trail = chg && (sck_s == ckp);
  assign s_smp = st_q.cke ? lead : trail;
  assign s_out = st_q.cke ? trail : lead;

  assign take = hsel_i && hready_i && htrans_i[1];
  assign rd_buf = take && !hwrite_i &&
                  (haddr_i[7:0] == `OFS_BUFFER);

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [7:0] rx_n;
    rx_n = st_q.rx;
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.rdy = 1'b1;
    st_d.sck_h = sck_s;

    // Register bus: address phase
    st_d.a_wr = take && hwrite_i;
    st_d.a_addr = haddr_i[7:0];
    if (take && !hwrite_i) begin
      unique case (haddr_i[7:0])
        `OFS_CONTROL: st_d.rdata = 32'(st_q.ctl);
        `OFS_STATUS: st_d.rdata = 32'({st_q.input_sample_point, st_q.cke,
                                       5'h00, st_q.bf});
        `OFS_BUFFER: st_d.rdata = 32'(st_q.rbuf);
        `OFS_IRQ_STAT: st_d.rdata = 32'(st_q.irq_st);
        `OFS_IRQ_MASK: st_d.rdata = 32'(st_q.irq_mk);
        default: st_d.rdata = '0;
      endcase
    end
    if (rd_buf) begin
      st_d.bf = 1'b0;
    end

    // Register bus: data phase
    if (st_q.a_wr) begin
      unique case (st_q.a_addr)
        `OFS_CONTROL: st_d.ctl = hwdata_i[5:0];
        `OFS_STATUS: begin
          st_d.input_sample_point = hwdata_i[`ST_SMP];
          st_d.cke = hwdata_i[`ST_CKE];
        end
        `OFS_BUFFER: begin
          // A write during a master word is dropped
          if (en && st_q.ph == PH_IDLE) begin
            st_d.tx = hwdata_i[7:0];
            if (st_q.cke) begin
              st_d.sdo = hwdata_i[7];
              st_d.tx = {hwdata_i[6:0], 1'b0};
            end
            if (master) begin
              st_d.ph = PH_RUN;
              st_d.hcnt = 5'h00;
              st_d.div = 7'h00;
            end
          end
        end
        `OFS_IRQ_STAT: begin
          st_d.irq_st = st_q.irq_st & ~hwdata_i[0];
        end
        `OFS_IRQ_MASK: st_d.irq_mk = hwdata_i[0];
        default: begin
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////
    // Shift engine

    if (!en || !master) begin
      st_d.ph = PH_IDLE;
    end
    if (!en || !slave || !sel) begin
      st_d.bits = 4'h0;
    end

    if (en && master && st_q.ph == PH_RUN) begin
      // Sampled data arrive two cycles late through the synchroniser
      if (tick) begin
        st_d.div = 7'h00;
        if (st_q.hcnt < `LAST_EDGE) begin
          st_d.sck = ~st_q.sck;
        end
        if (m_smp) begin
          rx_n = {st_q.rx[6:0], sdi_s};
        end
        if (m_out) begin
          st_d.sdo = st_q.tx[7];
          st_d.tx = {st_q.tx[6:0], 1'b0};
        end
        st_d.hcnt = 5'(st_q.hcnt + 5'h01);
        if (st_q.hcnt == `LAST_EDGE) begin
          st_d.ph = PH_IDLE;
          st_d.done = 1'b1;
        end
      end else begin
        st_d.div = 7'(st_q.div + 7'h01);
      end
    end else begin
      st_d.sck = ckp;
    end

    // Slave clock comes from the far master; no rate here
    if (en && slave && sel) begin
      if (s_smp) begin
        rx_n = {st_q.rx[6:0], sdi_s};
        st_d.bits = 4'(st_q.bits + 4'h1);
        if (st_q.bits == 4'h7) begin
          st_d.bits = 4'h0;
          st_d.done = 1'b1;
        end
      end
      if (s_out) begin
        st_d.sdo = st_q.tx[7];
        st_d.tx = {st_q.tx[6:0], 1'b0};
      end
    end
    st_d.rx = rx_n;

    // Completion wins over a read or clear in the same cycle
    if (st_d.done) begin
      st_d.rbuf = rx_n;
      st_d.bf = 1'b1;
      st_d.irq_st = 1'b1;
    end

    st_d.sck_oe = en && master;
    st_d.sdo_oe = en && (master || (slave && sel));
    st_d.irq = st_d.irq_st & st_d.irq_mk;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= '0;
      st_q.ctl <= `RST_CONTROL;
      st_q.rdy <= 1'b1;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign hrdata_o = st_q.rdata;
  assign hreadyout_o = st_q.rdy;
  assign hresp_o = 1'b0;
  assign sck_o = st_q.sck;
  assign sck_oe_o = st_q.sck_oe;
  assign sdo_o = st_q.sdo;
  assign sdo_oe_o = st_q.sdo_oe;
  assign irq_o = st_q.irq;

  ////////////////////////////////////////////////////////////////////
  // Checks (assume ce_i held high)

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_wr_ctl;
    take && hwrite_i && haddr_i[7:0] == `OFS_CONTROL ##1 1'b1;
  endsequence

  sequence s_wr_stat;
    take && hwrite_i && haddr_i[7:0] == `OFS_STATUS ##1 1'b1;
  endsequence

  sequence s_run_end;
    st_q.ph == PH_RUN ##1 st_q.ph == PH_IDLE;
  endsequence

  ctl_bits_a: assert property (
    s_wr_ctl |=> st_q.ctl == $past(hwdata_i[5:0]))
    else $error("control bits not stored");

  mode_bits_a: assert property (
    s_wr_stat |=> {st_q.input_sample_point, st_q.cke} == $past(hwdata_i[7:6]))
    else $error("status option bits not stored");

  word_end_a: assert property (
    s_run_end |-> st_q.done && st_q.hcnt == 5'h11)
    else $error("master word did not end after 16 edges");

  bf_set_a: assert property (
    st_d.done |=> st_q.bf && st_q.rbuf == $past(st_d.rx))
    else $error("buffer full not set on word");

  bf_clr_a: assert property (
    rd_buf && st_q.bf && !st_d.done |=> !st_q.bf)
    else $error("buffer read did not clear full");

  idle_level_a: assert property (
    en && st_q.ph == PH_IDLE && !st_q.a_wr |=> sck_o == $past(ckp))
    else $error("idle clock level wrong");

  master_oe_a: assert property (
    en && master |=> sck_oe_o)
    else $error("master not driving clock");

  slave_oe_a: assert property (
    en && slave |=> !sck_oe_o)
    else $error("slave driving clock");

  ss_gate_a: assert property (
    en && use_ss && ss_s |=> st_q.bits == 4'h0)
    else $error("deselected slave kept counting");

  rate_a: assert property (
    st_q.ph == PH_RUN && mode == `MODE_DIV16 && $changed(sck_o)
    |=> $stable(sck_o) [*7])
    else $error("clock half period too short");

  ss_ignored_a: assert property (
    en && master && st_q.ph == PH_RUN && st_q.hcnt != `LAST_EDGE &&
    !st_q.a_wr |=> st_q.ph == PH_RUN)
    else $error("master word stopped early");

  cke_out_a: assert property (
    en && slave && sel && s_out |=> sdo_o == $past(st_q.tx[7]))
    else $error("slave data not changed on chosen edge");

endmodule : serial_port

// [rtl/serial_port_defines.svh]
// Register offsets, field positions, reset values and rate counts
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

`define OFS_CONTROL 8'h90
`define OFS_STATUS 8'h94
`define OFS_BUFFER 8'h98
`define OFS_IRQ_STAT 8'h9C
`define OFS_IRQ_MASK 8'hA0

`define CTL_EN 5
`define CTL_CKP 4
`define ST_SMP 7
`define ST_CKE 6
`define ST_BF 0

`define RST_CONTROL 6'h00
`define RST_STATUS 8'h00

`define MODE_DIV4 4'h0
`define MODE_DIV16 4'h1
`define MODE_DIV64 4'h2
`define MODE_DIV128 4'h3
`define MODE_SLAVE_SS 4'h4
`define MODE_SLAVE_NOSS 4'h5

`define HALF_DIV4 7'h02
`define HALF_DIV16 7'h08
`define HALF_DIV64 7'h20
`define HALF_DIV128 7'h40
`define LAST_EDGE 5'h10

`endif

// [rtl/serial_port_pkg.sv]
// Types shared by the serial port modules
package serial_port_pkg;

  typedef logic [31:0] word_t;

  typedef enum logic {PH_IDLE, PH_RUN} phase_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } sync_state_t;

  typedef struct packed {
    logic [5:0] ctl;
    logic input_sample_point;
    logic cke;
    logic bf;
    logic [7:0] rbuf;
    logic [7:0] tx;
    logic [7:0] rx;
    logic sdo;
    logic sck;
    logic sck_h;
    phase_t ph;
    logic [4:0] hcnt;
    logic [6:0] div;
    logic [3:0] bits;
    logic done;
    logic irq_st;
    logic irq_mk;
    logic irq;
    logic sck_oe;
    logic sdo_oe;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] rdata;
    logic rdy;
  } core_state_t;

endpackage : serial_port_pkg

// [rtl/pin_sync_if.sv]
// Raw and synchronised serial pin levels
`timescale 1ns/1ns
interface pin_sync_if;
  logic [2:0] raw;
  logic [2:0] sync;
  modport pins (input raw, output sync);
  modport user (output raw, input sync);
endinterface : pin_sync_if

// [rtl/pin_sync.sv]
// Two-stage synchroniser for the serial pins
`timescale 1ns/1ns
module pin_sync (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  pin_sync_if.pins sp
);
  import serial_port_pkg::*;

  sync_state_t st_q;
  sync_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = sp.raw;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign sp.sync = st_q.s2;

endmodule : pin_sync

// [tb/spi_peer.sv]
// Far-side SPI device model: shifts on falling edge, samples on rising
`timescale 1ns/1ns
module spi_peer (
  input wire logic sck_i,
  input wire logic sdo_i,
  output logic sck_o,
  output logic sdi_o,
  output logic ss_n_o
);
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  int cnt;
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    ss_n_o = 1'b1;
    cnt = 8;
  end
  always @(posedge sck_i) begin
    rx_q = {rx_q[6:0], sdo_i};
    cnt++;
  end
  // Past the word the line toggles, so stale bits never pass for data
  always @(negedge sck_i) begin
    sdi_o = (cnt >= 8) ? ~sdi_o : tx_q[7-cnt];
  end
  task automatic load(input logic [7:0] b);
    tx_q = b;
    cnt = 0;
    sdi_o = b[7];
  endtask : load
  // As master: 80 ns link clock, idles low, select held over the word
  task automatic run(input logic [7:0] b);
    load(b);
    ss_n_o = 1'b0;
    repeat (8) begin
      #40 sck_o = 1'b1;
      #40 sck_o = 1'b0;
    end
    #40 ss_n_o = 1'b1;
  endtask : run
endmodule : spi_peer

// [tb/serial_port_tb.sv]
// Self-checking bench for the serial port in SPI mode
`timescale 1ns/1ns
`include "serial_port_defines.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  fail_count++; $display("wrong value %s exp %0h seen %0h", n, e, s); \
  end end
module serial_port_tb;
  import serial_port_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hsel_i = 1'b0;
  word_t haddr_i = '0;
  logic [1:0] htrans_i = 2'b00;
  logic hwrite_i = 1'b0;
  word_t hwdata_i = '0;
  logic [2:0] hsize_i = 3'b000;
  word_t hrdata_o;
  word_t rd;
  logic hreadyout_o, hresp_o, sck_o, sck_oe_o, sdo_o, sdo_oe_o, irq_o;
  logic p_sck, p_sdi, p_ss_n;
  wire logic sck_w = sck_oe_o ? sck_o : p_sck;
  // A released data line shows the inverse so a late enable is caught
  wire logic sdo_w = sdo_oe_o ? sdo_o : ~sdo_o;
  int fail_count = 0;
  int check_count = 0;
  int hi_cnt = 0;
  always #5 mclk_i = ~mclk_i;
  // Cycles spent with the serial clock high give the rate exactly
  always @(posedge mclk_i) hi_cnt <= hi_cnt + int'(sck_o);
  serial_port DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .sdi_i(p_sdi), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .ss_n_i(p_ss_n),
    .irq_o(irq_o));
  spi_peer peer (.sck_i(sck_w), .sdo_i(sdo_w), .sck_o(p_sck),
    .sdi_o(p_sdi), .ss_n_o(p_ss_n));
  ////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input word_t d);
    @(posedge mclk_i);
    hsel_i <= 1'b1;
    haddr_i <= word_t'(a);
    hwrite_i <= w;
    hsize_i <= 3'b010;
    htrans_i <= 2'b10;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    rd = hrdata_o;
  endtask : bus
  task automatic wr(input logic [7:0] a, input word_t d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input word_t e, input string n);
    bus(1'b0, a, '0);
    `CHK(n, e, rd)
    `CHK("hresp", 1'b0, hresp_o)
  endtask : rdc
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 2000) begin
      @(posedge mclk_i);
      n++;
    end
    `CHK("irq", 1'b1, irq_o)
  endtask : wait_irq
  task automatic t_reset;
    rdc(`OFS_CONTROL, 32'h0000_0000, "control");
    rdc(`OFS_STATUS, 32'h0000_0000, "status");
    wr(8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, 32'h0000_0000, "unmapped");
    wr(`OFS_CONTROL, 32'h0000_00FF);
    rdc(`OFS_CONTROL, 32'h0000_003F, "control");
    wr(`OFS_STATUS, 32'h0000_00FF);
    rdc(`OFS_STATUS, 32'h0000_00C0, "status");
    `CHK("sck idle", 1'b1, sck_o)
  endtask : t_reset
  task automatic t_master;
    int hi_exp[4] = '{16, 64, 256, 512};
    int base;
    logic [7:0] b;
    wr(`OFS_STATUS, 32'h0000_0040);
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    for (int m = 0; m < 4; m++) begin
      b = 8'h3C ^ 8'(m);
      wr(`OFS_CONTROL, word_t'(32'h0000_0020 + m));
      rdc(`OFS_STATUS, 32'h0000_0040, "status");
      `CHK("sck idle", 1'b0, sck_o)
      `CHK("sck drive", 1'b1, sck_oe_o)
      peer.load(~b);
      base = hi_cnt;
      wr(`OFS_BUFFER, word_t'(b));
      wait_irq();
      `CHK("high cycles", hi_exp[m], hi_cnt - base)
      `CHK("peer rx", b, peer.rx_q)
      rdc(`OFS_STATUS, 32'h0000_0041, "status");
      // Two-cycle half period is under the input setup, data not judged
      if (m > 0) rdc(`OFS_BUFFER, {24'h00_0000, ~b}, "rx word");
      else bus(1'b0, `OFS_BUFFER, '0);
      rdc(`OFS_STATUS, 32'h0000_0040, "status");
      wr(`OFS_IRQ_STAT, 32'h0000_0001);
      rdc(`OFS_IRQ_STAT, 32'h0000_0000, "irq status");
      `CHK("irq", 1'b0, irq_o)
    end
  endtask : t_master
  // Idle-high clock, data out on leading edge, sampled at end of bit
  task automatic t_alt;
    wr(`OFS_STATUS, 32'h0000_0080);
    wr(`OFS_CONTROL, 32'h0000_0031);
    rdc(`OFS_STATUS, 32'h0000_0080, "status");
    `CHK("sck idle", 1'b1, sck_o)
    `CHK("sck drive", 1'b1, sck_oe_o)
    peer.load(8'h5A);
    wr(`OFS_BUFFER, 32'h0000_00A5);
    wait_irq();
    `CHK("peer rx", 8'hA5, peer.rx_q)
    rdc(`OFS_BUFFER, 32'h0000_005A, "rx word");
    `CHK("sck idle", 1'b1, sck_o)
    wr(`OFS_IRQ_STAT, 32'h0000_0001);
  endtask : t_alt
  task automatic t_slave;
    wr(`OFS_STATUS, 32'h0000_0040);
    wr(`OFS_IRQ_MASK, 32'h0000_0000);
    wr(`OFS_CONTROL, 32'h0000_0024);
    rdc(`OFS_STATUS, 32'h0000_0040, "status");
    `CHK("sck drive", 1'b0, sck_oe_o)
    `CHK("sdo drive", 1'b0, sdo_oe_o)
    wr(`OFS_BUFFER, 32'h0000_005A);
    peer.run(8'hC3);
    rdc(`OFS_STATUS, 32'h0000_0041, "status");
    `CHK("peer rx", 8'h5A, peer.rx_q)
    `CHK("irq", 1'b0, irq_o)
    rdc(`OFS_IRQ_STAT, 32'h0000_0001, "irq status");
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    rdc(`OFS_BUFFER, 32'h0000_00C3, "rx word");
    `CHK("irq", 1'b1, irq_o)
    wr(`OFS_IRQ_STAT, 32'h0000_0001);
    rdc(`OFS_STATUS, 32'h0000_0040, "status");
    `CHK("irq", 1'b0, irq_o)
    wr(`OFS_CONTROL, 32'h0000_0025);
    rdc(`OFS_STATUS, 32'h0000_0040, "status");
    `CHK("sdo drive", 1'b1, sdo_oe_o)
  endtask : t_slave
  // Reset pulse in mid-run must drop enables and restore the registers
  task automatic t_rst2;
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    `CHK("sdo drive", 1'b0, sdo_oe_o)
    `CHK("sck drive", 1'b0, sck_oe_o)
    reset_n_i <= 1'b1;
    rdc(`OFS_CONTROL, 32'h0000_0000, "control");
    rdc(`OFS_STATUS, 32'h0000_0000, "status");
    `CHK("irq", 1'b0, irq_o)
  endtask : t_rst2
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  initial begin
    repeat (16) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_master();
    t_alt();
    t_slave();
    t_rst2();
    results();
  end
  // Whole run needs well under 10k cycles
  initial begin
    #500000;
    fail_count++;
    results();
  end
endmodule : serial_port_tb
